// ---- shared/cif_pkg.sv ----
// Shared constants, types and CRC helper for the card identification block
package cif_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CORE_CLK_MHZ    = 250;
    localparam int unsigned POWERUP_TIME_US = 1;
    localparam int unsigned POWERUP_CYCLES  = CORE_CLK_MHZ * POWERUP_TIME_US;
    localparam logic [1:0]  RESP_GAP_CLKS   = 2'h2;

    // ------------------------------------------------------------
    // Reset values and card properties
    // ------------------------------------------------------------
    localparam logic [15:0] RCA_DEFAULT     = 16'h0001;
    localparam logic [15:0] DSR_DEFAULT     = 16'h0404;
    localparam logic [30:0] OCR_WINDOW      = 31'h00ff8000;
    localparam logic [3:0]  STATUS_ST_IDENT = 4'h2;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam logic [5:0]  CMD_FRAME_LAST  = 6'h2f;
    localparam logic [7:0]  SHORT_RESP_BITS = 8'h30;
    localparam logic [7:0]  LONG_RESP_BITS  = 8'h88;

    // ------------------------------------------------------------
    // Command indices
    // ------------------------------------------------------------
    localparam logic [5:0]  CMD_GO_IDLE     = 6'h00;
    localparam logic [5:0]  CMD_OP_COND     = 6'h01;
    localparam logic [5:0]  CMD_ALL_CID     = 6'h02;
    localparam logic [5:0]  CMD_SET_ADDR    = 6'h03;
    localparam logic [5:0]  CMD_GO_INACTIVE = 6'h0f;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READY,
        ST_IDENT,
        ST_STBY,
        ST_INACTIVE
    } cif_state_t;

    typedef enum logic [1:0] {
        OP_IDENT,
        OP_XFER,
        OP_INACTIVE
    } cif_opmode_t;

    // CRC7, polynomial x^7 + x^3 + 1, over the first 40 frame bits
    function automatic logic [6:0] crc7(input logic [39:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c  = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ 7'h09;
            end
        end
        return c;
    endfunction

endpackage

// ---- tb/cif_card_id_fsm_bench.sv ----
// Self-checking bench for the card identification state machine
`timescale 1ns/100ps
`default_nettype none
module cif_card_id_fsm_bench;
    logic         core_clk_in, reset_in, spi_n, host_line, bus_clk, cmd_out, cmd_oe;
    logic         pp, spi, busy;
    logic [127:0] card_id;
    logic [135:0] resp;
    logic [2:0]   state;
    logic [1:0]   mode;
    logic [15:0]  rca, dsr, addr;
    logic [31:0]  win;
    int           err_total, n_compared, k, seed;
    wire          cmd_wire = host_line & (cmd_oe ? cmd_out : 1'b1);
    initial begin
        core_clk_in = 1'b0;
        forever #2 core_clk_in = ~core_clk_in;
    end
    // Long power-up so the first query still reports busy
    cif_card_id_fsm #(.POWERUP_CYCLES(5000)) dut (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .bus_clk_in(bus_clk), .cmd_in(cmd_wire), .spi_select_n_in(spi_n),
        .card_id_in(card_id), .cmd_out(cmd_out), .cmd_oe_out(cmd_oe), .card_state_out(state),
        .op_mode_out(mode), .push_pull_out(pp), .spi_mode_out(spi), .power_busy_out(busy),
        .rca_out(rca), .dsr_out(dsr));
    cif_host_model host (.line_in(cmd_wire), .bus_clk_out(bus_clk), .line_out(host_line));
    task automatic chk(input string what, input logic [135:0] exp, input logic [135:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("compared %0d mismatched %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic run(input logic [5:0] idx, input logic [31:0] arg, input int nb, input int jam);
        host.xact(idx, arg, nb, jam, resp, k);
        #20;
    endtask
    function automatic logic [47:0] r3(input logic rdy);
        return {2'b00, 6'h3f, rdy, 31'h00ff8000, 8'hff};
    endfunction
    initial begin
        #400000;
        err_total++;
        conclude();
    end
    initial begin
        err_total = 0;
        n_compared = 0;
        seed = $urandom(69972);
        reset_in = 1'b1;
        spi_n = 1'b1;
        card_id = {$urandom, $urandom, $urandom, $urandom};
        repeat (3) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        chk("reset", {3'h0, 16'h0001, 16'h0404, 2'b10}, {state, rca, dsr, busy, cmd_oe});
        run(6'h02, 32'h0, 0, -1);
        chk("idle cmd2", {1'b0, 3'h0}, {k >= 0, state});
        run(6'h01, 32'h0, 48, -1);
        chk("query", r3(1'b0), resp[47:0]);
        $display("reset test done");
        for (int p = 0; p < 2; p++) begin
            win = ($urandom & 32'h00ff8000) | 32'h00008000;
            addr = 16'($urandom);
            // Repeat while busy; a later window change must be ignored
            for (int t = 0; t < 3 && state != 3'h1; t++) begin
                run(6'h01, (p == 1 && t > 0) ? 32'h00000100 : win, 48, -1);
            end
            chk("ready", {r3(1'b1), 3'h1}, {resp[47:0], state});
            run(6'h02, 32'h0, 136, 2);
            chk("lost", {{133{1'b1}}, 3'h1}, {resp[132:0], state});
            run(6'h02, 32'h0, 136, -1);
            chk("cid", {2'b00, 6'h3f, card_id[127:1], 1'b1}, resp);
            chk("ident", 3'h2, state);
            run(6'h03, {addr, 16'h0}, 48, -1);
            chk("r1", {6'h03, 4'h2}, {resp[45:40], resp[20:17]});
            chk("stby", {3'h3, 2'h1, 1'b1, addr}, {state, mode, pp, rca});
            for (int c = 1; c < 4; c++) begin
                run(6'(c), win, 0, -1);
                chk("id ignored", {1'b0, 3'h3}, {k >= 0, state});
            end
            run(6'h0f, {~addr, 16'h0}, 0, -1);
            chk("cmd15 other", 3'h3, state);
            run(p ? 6'h0f : 6'h00, {addr, 16'h0}, 0, -1);
            chk("exit", p ? {3'h4, 2'h2, addr} : {3'h0, 2'h0, 16'h0001}, {state, mode, rca});
            $display("pass %0d done", p);
        end
        run(6'h00, 32'h0, 0, -1);
        run(6'h01, win, 0, -1);
        chk("inactive", {1'b0, 3'h4}, {k >= 0, state});
        @(posedge core_clk_in);
        spi_n <= 1'b0;
        run(6'h00, 32'h0, 0, -1);
        chk("spi", {1'b1, 3'h4}, {spi, state});
        $display("inactive test done");
        @(posedge core_clk_in);
        spi_n <= 1'b1;
        reset_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        reset_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
        chk("power on", {3'h0, 1'b0}, {state, spi});
        run(6'h01, 32'h00000100, 0, -1);
        chk("bad window", {1'b0, 3'h4}, {k >= 0, state});
        $display("power-on test done");
        conclude();
    end
endmodule
bind cif_card_id_fsm cif_monitor mon (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .cmd_out(cmd_out),
    .cmd_oe_out(cmd_oe_out), .card_state_out(card_state_out), .op_mode_out(op_mode_out),
    .push_pull_out(push_pull_out), .spi_mode_out(spi_mode_out),
    .power_busy_out(power_busy_out), .rca_out(rca_out), .dsr_out(dsr_out));
`default_nettype wire

// ---- tb/cif_host_model.sv ----
// Behavioural host: clocks command frames and captures replies
`timescale 1ns/100ps
`default_nettype none
module cif_host_model (
    input  wire logic line_in,
    output var logic  bus_clk_out,
    output var logic  line_out
);
    initial begin
        bus_clk_out = 1'b0;
        line_out    = 1'b1;
    end
    function automatic logic [6:0] crc(input logic [39:0] d);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 39; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
        end
        return c;
    endfunction
    // Clock runs only inside a transaction (command frame plus reply window); jam pulls one reply bit low like a rival card
    task automatic xact(input logic [5:0] idx, input logic [31:0] arg, input int nbits,
                        input int jam, output logic [135:0] resp, output int k);
        logic [47:0] f;
        f = {2'b01, idx, arg, crc({2'b01, idx, arg}), 1'b1};
        resp = '1;
        k = -1;
        #1;
        for (int i = 0; i < 48; i++) begin
            line_out = f[47 - i];
            #40 bus_clk_out = 1'b1;
            #40 bus_clk_out = 1'b0;
        end
        for (int i = 0; i < nbits + 12; i++) begin
            line_out = !(k >= 0 && k + 1 == jam);
            #40 bus_clk_out = 1'b1;
            if (k < 0 ? !line_in : k < nbits - 1) begin
                k++;
                resp = {resp[134:0], line_in};
            end
            #40 bus_clk_out = 1'b0;
        end
        line_out = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- tb/cif_monitor.sv ----
// Port-level assertions for the identification state machine
`timescale 1ns/100ps
`default_nettype none
module cif_monitor (
    input  wire logic         core_clk_in,
    input  wire logic         reset_in,
    input  wire logic         cmd_out,
    input  wire logic         cmd_oe_out,
    input  wire logic [2:0]   card_state_out,
    input  wire logic [1:0]   op_mode_out,
    input  wire logic         push_pull_out,
    input  wire logic         spi_mode_out,
    input  wire logic         power_busy_out,
    input  wire logic [15:0]  rca_out,
    input  wire logic [15:0]  dsr_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    sequence s_into(logic [2:0] st);
        card_state_out == st && $past(card_state_out) != st;
    endsequence
    a_od_low_only: assert property (cmd_oe_out && !push_pull_out |-> !cmd_out)
        else $error("open-drain driver drove high");
    a_mode_map: assert property (op_mode_out == (card_state_out == 3'h4 ? 2'h2 :
        (card_state_out == 3'h3 ? 2'h1 : 2'h0))) else $error("mode does not fit state");
    a_pp_in_stby: assert property (push_pull_out == (card_state_out == 3'h3))
        else $error("push-pull outside stand-by");
    a_inactive_stays: assert property (card_state_out == 3'h4 |=> card_state_out == 3'h4
        && !cmd_oe_out) else $error("left inactive or drove line");
    a_reset_defaults: assert property (disable iff (1'b0) reset_in |=> card_state_out == 3'h0
        && rca_out == 16'h0001 && dsr_out == 16'h0404 && !cmd_oe_out) else $error("bad reset");
    a_ident_entry: assert property (s_into(3'h2) |-> $past(card_state_out) == 3'h1)
        else $error("ident entered not from ready");
    a_stby_entry: assert property (s_into(3'h3) |-> $past(card_state_out) == 3'h2)
        else $error("stand-by entered not from ident");
    a_rca_hold: assert property (!$stable(rca_out) |-> card_state_out inside {3'h0, 3'h3})
        else $error("address changed outside assignment");
    a_busy_after_rst: assert property ($fell(reset_in) |-> power_busy_out [*8])
        else $error("busy cleared too early");
    a_spi_sticky: assert property (spi_mode_out |=> spi_mode_out)
        else $error("spi flag dropped");
    a_dsr_fixed: assert property ($stable(dsr_out))
        else $error("driver stage changed");
endmodule
`default_nettype wire

// ---- verilog/cif_card_id_fsm.sv ----
// Card-side identification phase state machine
//
// What this block does
// [RULE1] Host starts all traffic; card only answers
// [RULE2] Own-address and some broadcast commands get responses
// [RULE3] Stay in identification until address assignment
// [RULE4] Interrupt mode entered and left jointly
// [RULE5] Each state maps to mode and bus drive
// [RULE6] Power-on starts in Idle, native mode
// [RULE7] Reset command goes Idle or SPI
// [RULE8] Reset floats outputs, defaults address and drivers
// [RULE9] Reset command refused in Inactive, except SPI
// [RULE10] Bad voltage window sends card Inactive
// [RULE11] Zero window queries; host then picks window
// [RULE12] Busy bit set until power-up completes
// [RULE13] Window change during initialisation is ignored
// [RULE14] Addressed deactivate with matching address: Inactive
// [RULE15] Inactive left only by power cycle
// [RULE16] Host begins open-drain at slow clock
// [RULE17] Open-drain responses drive only low levels
// [RULE18] Identification number arbitration; loser stays Ready
// [RULE19] Arbitration winner moves to Identification state
// [RULE20] Address assignment: Stand-by, push-pull, ignore identification
// [RULE21] Host repeats identification until timeout
// [RULE22] Relative address is 16 bits, host-written
// [RULE23] Driver-stage setting resets to 0x404
// [RULE24] Addressed card ignores identification commands
// [RULE25] Invalid commands ignored without response
`timescale 1ns/100ps
`default_nettype none
module cif_card_id_fsm #(
    parameter int unsigned POWERUP_CYCLES = cif_pkg::POWERUP_CYCLES
) (
    input  wire logic         core_clk_in,
    input  wire logic         reset_in,
    input  wire logic         bus_clk_in,
    input  wire logic         cmd_in,
    input  wire logic         spi_select_n_in,
    input  wire logic [127:0] card_id_in,
    output logic              cmd_out,
    output logic              cmd_oe_out,
    output logic [2:0]        card_state_out,
    output logic [1:0]        op_mode_out,
    output logic              push_pull_out,
    output logic              spi_mode_out,
    output logic              power_busy_out,
    output logic [15:0]       rca_out,
    output logic [15:0]       dsr_out
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                clk_s1;
        logic                clk_s2;
        logic                clk_prev;
        logic                cmd_s1;
        logic                cmd_s2;
        logic                cs_s1;
        logic                cs_s2;
        cif_pkg::cif_state_t state;
        logic [15:0]         rca;
        logic [15:0]         dsr;
        logic                win_set;
        logic [30:0]         win;
        logic [15:0]         pu_cnt;
        logic                pu_done;
        logic                spi;
        logic                cid_pend;
        logic                start;
        logic [135:0]        frame;
        logic [7:0]          len;
        logic                arb;
    } cif_fsm_t;

    cif_fsm_t s_ff;
    cif_fsm_t nxt_s;

    logic        bit_rise;
    logic        bit_fall;
    logic        rx_valid;
    logic [5:0]  rx_index;
    logic [31:0] rx_arg;
    logic        tx_busy;
    logic        tx_done;
    logic        tx_lost;
    logic        pp_mode;
    logic [31:0] ocr;
    logic [31:0] status;
    logic [30:0] eff_win;
    logic [39:0] r1_head;

    // Edges found on the synchronised link clock only
    assign bit_rise = s_ff.clk_s2 & ~s_ff.clk_prev;
    assign bit_fall = ~s_ff.clk_s2 & s_ff.clk_prev;
    assign pp_mode  = (s_ff.state == cif_pkg::ST_STBY); // [RULE5] [RULE20]

    // ------------------------------------------------------------
    // Frame engines
    // ------------------------------------------------------------
    cif_cmd_rx u_rx (
        .core_clk_in   (core_clk_in),
        .reset_in      (reset_in),
        .bit_rise_in   (bit_rise),
        .cmd_bit_in    (s_ff.cmd_s2),
        .enable_in     (~tx_busy & ~s_ff.start & ~s_ff.spi),
        .cmd_valid_out (rx_valid),
        .cmd_index_out (rx_index),
        .cmd_arg_out   (rx_arg)
    );

    cif_resp_tx u_tx (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .bit_rise_in  (bit_rise),
        .bit_fall_in  (bit_fall),
        .cmd_line_in  (s_ff.cmd_s2),
        .start_in     (s_ff.start),
        .frame_in     (s_ff.frame),
        .len_in       (s_ff.len),
        .arb_in       (s_ff.arb),
        .push_pull_in (pp_mode),
        .busy_out     (tx_busy),
        .done_out     (tx_done),
        .lost_out     (tx_lost),
        .cmd_out      (cmd_out),
        .cmd_oe_out   (cmd_oe_out)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s          = s_ff;
        nxt_s.clk_s1   = bus_clk_in;
        nxt_s.clk_s2   = s_ff.clk_s1;
        nxt_s.clk_prev = s_ff.clk_s2;
        nxt_s.cmd_s1   = cmd_in;
        nxt_s.cmd_s2   = s_ff.cmd_s1;
        nxt_s.cs_s1    = spi_select_n_in;
        nxt_s.cs_s2    = s_ff.cs_s1;
        nxt_s.start    = 1'b0;

        // Busy bit in the op-condition reply tracks this
        ocr     = {s_ff.pu_done, cif_pkg::OCR_WINDOW};                   // [RULE12]
        eff_win = s_ff.win_set ? s_ff.win : rx_arg[30:0];               // [RULE13]
        status  = 32'h0;
        status[12:9] = cif_pkg::STATUS_ST_IDENT;
        r1_head = {2'b00, cif_pkg::CMD_SET_ADDR, status};

        if (!s_ff.pu_done) begin
            if (s_ff.pu_cnt == 16'(POWERUP_CYCLES - 1)) begin
                nxt_s.pu_done = 1'b1;
            end else begin
                nxt_s.pu_cnt = s_ff.pu_cnt + 16'h0001;
            end
        end

        // Outcome of identification-number arbitration
        if (s_ff.cid_pend && tx_done) begin
            nxt_s.cid_pend = 1'b0;
            nxt_s.state    = cif_pkg::ST_IDENT;   // [RULE19]
        end else if (s_ff.cid_pend && tx_lost) begin
            nxt_s.cid_pend = 1'b0;                // [RULE18]
        end

        // Only host commands trigger anything here
        if (rx_valid) begin                       // [RULE1]
            if (rx_index == cif_pkg::CMD_GO_IDLE) begin
                if (!s_ff.cs_s2) begin
                    nxt_s.spi = 1'b1;             // [RULE7] [RULE9]
                end
                if (s_ff.state != cif_pkg::ST_INACTIVE) begin
                    // Software reset also restarts the power-up procedure
                    nxt_s.state    = cif_pkg::ST_IDLE;           // [RULE7] [RULE9]
                    nxt_s.rca      = cif_pkg::RCA_DEFAULT;       // [RULE8]
                    nxt_s.dsr      = cif_pkg::DSR_DEFAULT;       // [RULE8] [RULE23]
                    nxt_s.win_set  = 1'b0;                       // [RULE13]
                    nxt_s.pu_cnt   = 16'h0000;
                    nxt_s.pu_done  = 1'b0;
                    nxt_s.cid_pend = 1'b0;
                end
            end else begin
                case (s_ff.state)
                    cif_pkg::ST_IDLE: begin
                        if (rx_index == cif_pkg::CMD_OP_COND) begin
                            if (rx_arg[30:0] == 31'h0) begin
                                // Query only: reply, no state change
                                nxt_s.start = 1'b1;             // [RULE11] [RULE2]
                            end else if ((eff_win & cif_pkg::OCR_WINDOW) == 31'h0) begin
                                nxt_s.state = cif_pkg::ST_INACTIVE; // [RULE10]
                            end else begin
                                nxt_s.start   = 1'b1;           // [RULE10] [RULE2]
                                nxt_s.win_set = 1'b1;
                                nxt_s.win     = eff_win;        // [RULE13]
                                if (s_ff.pu_done) begin
                                    nxt_s.state = cif_pkg::ST_READY; // [RULE12]
                                end
                            end
                            nxt_s.frame = {2'b00, 6'h3f, ocr, 7'h7f, 1'b1, 88'h0};
                            nxt_s.len   = cif_pkg::SHORT_RESP_BITS;
                            nxt_s.arb   = 1'b0;
                        end
                    end
                    cif_pkg::ST_READY: begin
                        if (rx_index == cif_pkg::CMD_ALL_CID) begin
                            nxt_s.start    = 1'b1;              // [RULE18] [RULE2]
                            nxt_s.cid_pend = 1'b1;
                            nxt_s.frame    = {2'b00, 6'h3f, card_id_in[127:1], 1'b1};
                            nxt_s.len      = cif_pkg::LONG_RESP_BITS;
                            nxt_s.arb      = 1'b1;              // [RULE18]
                        end
                    end
                    cif_pkg::ST_IDENT: begin
                        if (rx_index == cif_pkg::CMD_SET_ADDR) begin
                            nxt_s.rca   = rx_arg[31:16];        // [RULE22]
                            nxt_s.state = cif_pkg::ST_STBY;     // [RULE3] [RULE20]
                            nxt_s.start = 1'b1;                 // [RULE2]
                            nxt_s.frame = {r1_head, cif_pkg::crc7(r1_head), 1'b1, 88'h0};
                            nxt_s.len   = cif_pkg::SHORT_RESP_BITS;
                            nxt_s.arb   = 1'b0;
                        end
                    end
                    cif_pkg::ST_STBY: begin
                        // Identification commands fall through unanswered
                        if (rx_index == cif_pkg::CMD_GO_INACTIVE &&
                            rx_arg[31:16] == s_ff.rca) begin
                            nxt_s.state = cif_pkg::ST_INACTIVE; // [RULE14] [RULE24]
                        end
                    end
                    cif_pkg::ST_INACTIVE: begin
                        nxt_s.state = cif_pkg::ST_INACTIVE;     // [RULE15]
                    end
                    default: begin
                        nxt_s.state = cif_pkg::ST_IDLE;         // [RULE25]
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s_ff         <= '0;
            s_ff.clk_s1  <= 1'b0;
            s_ff.clk_s2  <= 1'b0;
            s_ff.clk_prev <= 1'b0;
            s_ff.cmd_s1  <= 1'b1;
            s_ff.cmd_s2  <= 1'b1;
            s_ff.cs_s1   <= 1'b1;
            s_ff.cs_s2   <= 1'b1;
            s_ff.state   <= cif_pkg::ST_IDLE;         // [RULE6]
            s_ff.rca     <= cif_pkg::RCA_DEFAULT;     // [RULE8]
            s_ff.dsr     <= cif_pkg::DSR_DEFAULT;     // [RULE23]
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Wait-IRQ is never entered here, so interrupt mode cannot desync
    always_comb begin
        case (s_ff.state)
            cif_pkg::ST_STBY:     op_mode_out = 2'(cif_pkg::OP_XFER);     // [RULE5] [RULE4]
            cif_pkg::ST_INACTIVE: op_mode_out = 2'(cif_pkg::OP_INACTIVE); // [RULE5]
            default:              op_mode_out = 2'(cif_pkg::OP_IDENT);    // [RULE3]
        endcase
    end

    assign card_state_out = 3'(s_ff.state);
    assign push_pull_out  = pp_mode;
    assign spi_mode_out   = s_ff.spi;
    assign power_busy_out = ~s_ff.pu_done;
    assign rca_out        = s_ff.rca;
    assign dsr_out        = s_ff.dsr;

endmodule
`default_nettype wire

// ---- verilog/cif_cmd_rx.sv ----
// Command frame receiver: deserialises and checks host commands
`timescale 1ns/100ps
`default_nettype none
module cif_cmd_rx (
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    input  wire logic        bit_rise_in,
    input  wire logic        cmd_bit_in,
    input  wire logic        enable_in,
    output logic             cmd_valid_out,
    output logic [5:0]       cmd_index_out,
    output logic [31:0]      cmd_arg_out
);

    typedef struct packed {
        logic        busy;
        logic [5:0]  cnt;
        logic [46:0] sh;
        logic        valid;
        logic [5:0]  index;
        logic [31:0] arg;
    } cif_rx_t;

    cif_rx_t s_ff;
    cif_rx_t nxt_s;
    logic [47:0] frm;

    always_comb begin
        nxt_s       = s_ff;
        nxt_s.valid = 1'b0;
        frm         = {s_ff.sh, cmd_bit_in};
        if (bit_rise_in) begin
            if (!s_ff.busy) begin
                // Start bit only; line held high otherwise
                if (enable_in && !cmd_bit_in) begin
                    nxt_s.busy = 1'b1;
                    nxt_s.cnt  = 6'h01;
                    nxt_s.sh   = 47'h0;
                end
            end else begin
                nxt_s.sh  = frm[46:0];
                nxt_s.cnt = s_ff.cnt + 6'h01;
                if (s_ff.cnt == cif_pkg::CMD_FRAME_LAST) begin
                    nxt_s.busy = 1'b0;
                    // Bad CRC or framing: drop silently
                    if (frm[46] && frm[0] && frm[7:1] == cif_pkg::crc7(frm[47:8])) begin
                        nxt_s.valid = 1'b1;
                        nxt_s.index = frm[45:40];
                        nxt_s.arg   = frm[39:8];
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign cmd_valid_out = s_ff.valid;
    assign cmd_index_out = s_ff.index;
    assign cmd_arg_out   = s_ff.arg;

endmodule
`default_nettype wire

// ---- verilog/cif_resp_tx.sv ----
// Response serialiser with open-drain arbitration on the command line
`timescale 1ns/100ps
`default_nettype none
module cif_resp_tx (
    input  wire logic         core_clk_in,
    input  wire logic         reset_in,
    input  wire logic         bit_rise_in,
    input  wire logic         bit_fall_in,
    input  wire logic         cmd_line_in,
    input  wire logic         start_in,
    input  wire logic [135:0] frame_in,
    input  wire logic [7:0]   len_in,
    input  wire logic         arb_in,
    input  wire logic         push_pull_in,
    output logic              busy_out,
    output logic              done_out,
    output logic              lost_out,
    output logic              cmd_out,
    output logic              cmd_oe_out
);

    typedef struct packed {
        logic         busy;
        logic         drive;
        logic [1:0]   gap;
        logic [7:0]   left;
        logic [135:0] sh;
        logic         arb;
        logic         pp;
        logic         cur;
        logic         out;
        logic         oe;
        logic         done;
        logic         lost;
    } cif_tx_t;

    cif_tx_t s_ff;
    cif_tx_t nxt_s;

    always_comb begin
        nxt_s      = s_ff;
        nxt_s.done = 1'b0;
        nxt_s.lost = 1'b0;
        if (start_in && !s_ff.busy) begin
            nxt_s.busy = 1'b1;
            nxt_s.gap  = cif_pkg::RESP_GAP_CLKS;
            nxt_s.left = len_in;
            nxt_s.sh   = frame_in;
            nxt_s.arb  = arb_in;
            nxt_s.pp   = push_pull_in;
        end else if (s_ff.busy) begin
            // Bits change on the falling link edge, host samples on rising
            if (bit_fall_in) begin
                if (s_ff.gap != 2'h0) begin
                    nxt_s.gap = s_ff.gap - 2'h1;
                end else if (s_ff.left != 8'h00) begin
                    nxt_s.cur   = s_ff.sh[135];
                    nxt_s.sh    = {s_ff.sh[134:0], 1'b0};
                    nxt_s.left  = s_ff.left - 8'h01;
                    nxt_s.drive = 1'b1;
                    nxt_s.oe    = s_ff.pp | ~s_ff.sh[135]; // [RULE17] [RULE20]
                    nxt_s.out   = s_ff.pp & s_ff.sh[135];  // [RULE17]
                end else begin
                    nxt_s.busy  = 1'b0;
                    nxt_s.drive = 1'b0;
                    nxt_s.oe    = 1'b0;
                    nxt_s.done  = 1'b1;
                end
            end
            // Wired-AND pulled our high bit low: another card wins
            if (bit_rise_in && s_ff.drive && s_ff.arb && cmd_line_in != s_ff.cur) begin
                nxt_s.busy  = 1'b0; // [RULE18]
                nxt_s.drive = 1'b0;
                nxt_s.oe    = 1'b0;
                nxt_s.lost  = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign busy_out   = s_ff.busy;
    assign done_out   = s_ff.done;
    assign lost_out   = s_ff.lost;
    assign cmd_out    = s_ff.out;
    assign cmd_oe_out = s_ff.oe;

endmodule
`default_nettype wire
